/* File: bench/can_engine_model.sv */
// protocol engine stand-in that pulses mailbox events
`timescale 1ns/1ps
`default_nettype none
module can_engine_model
(
    // clock
    input  wire logic aclk,
    // mailbox events
    output logic       movein_start,
    output logic       movein_done,
    output logic [4:0] movein_idx,
    output logic       remote_req_hit,
    output logic [4:0] remote_req_idx,
    output logic       tx_done,
    output logic [4:0] tx_idx
);
    logic [3:0] ev = 4'h0;
    logic [4:0] idx = 5'h0;
    assign movein_start   = ev[0];
    assign movein_done    = ev[1];
    assign remote_req_hit = ev[2];
    assign tx_done        = ev[3];
    assign movein_idx     = idx;
    assign remote_req_idx = idx;
    assign tx_idx         = idx;
    // idle index is inverted so a stale sample never matches by luck
    task automatic pulse(input int k, input logic [4:0] i);
        @(posedge aclk);
        ev  <= 4'h1 << k;
        idx <= i;
        @(posedge aclk);
        ev  <= 4'h0;
        idx <= ~i;
    endtask
endmodule
`default_nettype wire

/* File: bench/can_mailbox_code_fsm_bench.sv */
// self-checking bench for the mailbox code block
`timescale 1ns/1ps
`default_nettype none
module can_mailbox_code_fsm_bench;
    import can_mailbox_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = '0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = '0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic        movein_start, movein_done, remote_req_hit, tx_done;
    logic [4:0]  movein_idx, remote_req_idx, tx_idx;
    logic [31:0] rx_match_enable, tx_arb_enable, tx_remote_frame;
    logic [31:0] d;
    logic [1:0]  resp;
    logic [3:0]  rx_exp [4] = '{4'h6, 4'h6, 4'h2, 4'h2};
    logic [3:0]  tx_code [6] = '{4'h8, 4'h9, 4'hc, 4'hc, 4'he, 4'he};
    logic [3:0]  tx_after [6] = '{4'h8, 4'h9, 4'h8, 4'h4, 4'ha, 4'ha};
    logic [5:0]  tx_rtr = 6'b011000;
    logic [5:0]  tx_arb = 6'b111100;
    int          num_errors = 0;
    int          checks_done = 0;

    always #20 aclk = ~aclk;

    can_mailbox_code_fsm can_mailbox_code_fsm_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .movein_start, .movein_done,
        .movein_idx, .remote_req_hit, .remote_req_idx, .tx_done, .tx_idx,
        .rx_match_enable, .tx_arb_enable, .tx_remote_frame
    );
    can_engine_model can_engine_model_i (
        .aclk, .movein_start, .movein_done, .movein_idx, .remote_req_hit,
        .remote_req_idx, .tx_done, .tx_idx
    );

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic timeout();
        num_errors++;
        $display("MISMATCH at %0t: bus wait ran out", $time);
        final_report();
    endtask

    // first edge gap keeps a ready release and the next request apart
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        repeat (100)
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        timeout();
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        repeat (100)
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                v = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        timeout();
    endtask

    task automatic code(input int mb, input logic [3:0] e);
        rd(MB_BASE_OFF + 12'(4 * mb), d);
        chk({28'h0, d[27:24]}, {28'h0, e});
    endtask

    task automatic mv(input logic [4:0] i, input int gap);
        can_engine_model_i.pulse(0, i);
        repeat (gap) @(posedge aclk);
        can_engine_model_i.pulse(1, i);
    endtask

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        code(3, 4'h0);
        chk(rx_match_enable, 32'h0);
        rd(12'h100, d);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        wr(12'h100, 32'h0);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        $display("test reset done");
        wr(12'h08c, 32'h0400_0000);
        chk(32'(rx_match_enable[3]), 32'h1);
        can_engine_model_i.pulse(0, 5'd3);
        code(3, 4'h5);
        chk(32'(rx_match_enable[3]), 32'h0);
        can_engine_model_i.pulse(1, 5'd3);
        code(3, 4'h2);
        for (int k = 0; k < 4; k++)
        begin
            if (k > 1)
                rd(k == 2 ? TIMER_OFF : 12'h090, d);
            mv(5'd3, 3 * k);
            code(3, rx_exp[k]);
        end
        $display("test receive done");
        wr(SECOND_CTRL_OFF, 32'h0);
        wr(12'h094, 32'h0a00_0000);
        chk(32'(rx_match_enable[5]), 32'h1);
        can_engine_model_i.pulse(2, 5'd5);
        code(5, 4'he);
        chk(32'(tx_arb_enable[5]), 32'h1);
        can_engine_model_i.pulse(3, 5'd5);
        code(5, 4'ha);
        wr(SECOND_CTRL_OFF, 32'h1);
        chk({30'h0, rx_match_enable[5], tx_arb_enable[5]}, 32'h0);
        can_engine_model_i.pulse(2, 5'd5);
        code(5, 4'ha);
        $display("test answer done");
        wr(FIRST_CTRL_OFF, 32'h1);
        rd(FIRST_CTRL_OFF, d);
        chk(d, 32'h1);
        wr(TIMER_OFF, 32'h0);
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
        for (int k = 0; k < 6; k++)
        begin
            wr(12'h09c, {4'h0, tx_code[k], 3'h0, tx_rtr[k], 20'h0});
            chk({30'h0, tx_arb_enable[7], tx_remote_frame[7]}, {30'h0, tx_arb[k], tx_rtr[k]});
            can_engine_model_i.pulse(3, 5'd7);
            code(7, tx_after[k]);
        end
        $display("test transmit done");
        final_report();
    end
endmodule
`default_nettype wire

/* File: bench/can_mailbox_properties.sv */
// port assertions for the mailbox code block
`timescale 1ns/1ps
`default_nettype none
module can_mailbox_checker
    import can_mailbox_pkg::*;
#(
    parameter int N_MB = MB_COUNT
)
(
    // clock and reset
    input wire logic                    aclk,
    input wire logic                    aresetn,
    // register bus
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire logic [1:0]              s_axi_bresp,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_bready,
    input wire logic [ADDR_W-1:0]       s_axi_araddr,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic [DATA_W-1:0]       s_axi_rdata,
    input wire logic [1:0]              s_axi_rresp,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready,
    // engine side
    input wire logic                    movein_done,
    input wire logic                    remote_req_hit,
    input wire logic                    tx_done,
    input wire logic [$clog2(N_MB)-1:0] tx_idx,
    input wire logic [N_MB-1:0]         rx_match_enable,
    input wire logic [N_MB-1:0]         tx_arb_enable
);
    localparam logic [11:0] MB_END = MB_BASE_OFF + 12'(4 * N_MB);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // a write may land with bvalid or one cycle after it, so both count
    match_rise_cause_a:
    assert property ((rx_match_enable & ~$past(rx_match_enable)) != '0
        |-> $past(movein_done) || $past(tx_done) || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("match enable rose without cause");
    arb_rise_cause_a:
    assert property ((tx_arb_enable & ~$past(tx_arb_enable)) != '0
        |-> $past(remote_req_hit) || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("arbitration enable rose without cause");
    tx_done_clears_a:
    assert property (tx_done && tx_arb_enable[tx_idx] |=> !tx_arb_enable[$past(tx_idx)])
        else $error("mailbox still arbitrating after transmission");
    rd_slverr_a:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= MB_END
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0)
        else $error("unmapped read not refused");
    rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rd_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped before rready");
    wr_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
    wr_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    busy_ready_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    cover property (movein_done);
    cover property (remote_req_hit);
    cover property (tx_done && tx_arb_enable[tx_idx]);
endmodule
bind can_mailbox_code_fsm can_mailbox_checker #(.N_MB(N_MB)) can_mailbox_checker_i (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .movein_done, .remote_req_hit, .tx_done, .tx_idx, .rx_match_enable, .tx_arb_enable
);
`default_nettype wire

/* File: hdl/can_mailbox_code_fsm.sv */
// mailbox code field state logic with an axi4-lite register slave
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module can_mailbox_code_fsm
    import can_mailbox_pkg::*;
#(
    parameter int N_MB = MB_COUNT
)
(
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // axi4-lite write data
    input  wire logic [DATA_W-1:0]     s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // axi4-lite read data
    output logic [DATA_W-1:0]          s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // protocol engine events
    input  wire logic                  movein_start,
    input  wire logic                  movein_done,
    input  wire logic [$clog2(N_MB)-1:0] movein_idx,
    input  wire logic                  remote_req_hit,
    input  wire logic [$clog2(N_MB)-1:0] remote_req_idx,
    input  wire logic                  tx_done,
    input  wire logic [$clog2(N_MB)-1:0] tx_idx,
    // per-mailbox participation towards the engine
    output logic [N_MB-1:0]            rx_match_enable,
    output logic [N_MB-1:0]            tx_arb_enable,
    output logic [N_MB-1:0]            tx_remote_frame
);

    localparam int IDX_W = $clog2(N_MB);

    // control and mailbox state
    logic [3:0]            code [N_MB];
    logic [N_MB-1:0]       rtr;
    logic [N_MB-1:0]       fdf;
    logic [N_MB-1:0]       serviced;
    logic                  busy_read_enable_bit;
    logic                  remote_request_stored_bit;
    logic [TIMER_W-1:0]    timer;
    logic                  locked;
    logic [IDX_W-1:0]      lock_idx;

    // write channel holding state
    logic                  aw_have;
    logic                  w_have;
    logic [ADDR_W-1:0]     wr_addr;
    logic [DATA_W-1:0]     wr_data;
    logic [3:0]            wr_strb;

    // write decode
    wire                   wr_fire     = aw_have && w_have && !s_axi_bvalid;
    wire [ADDR_W-1:0]      wr_mb_off   = wr_addr - MB_BASE_OFF;
    wire [IDX_W-1:0]       wr_idx      = wr_mb_off[IDX_W+1:2];
    wire                   wr_mb_hit   = (wr_addr >= MB_BASE_OFF)
                                         && (32'(wr_mb_off[ADDR_W-1:2]) < N_MB);
    wire                   wr_first    = wr_addr[ADDR_W-1:2] == FIRST_CTRL_OFF[ADDR_W-1:2];
    wire                   wr_second   = wr_addr[ADDR_W-1:2] == SECOND_CTRL_OFF[ADDR_W-1:2];
    wire                   wr_timer    = wr_addr[ADDR_W-1:2] == TIMER_OFF[ADDR_W-1:2];
    wire                   wr_mapped   = wr_mb_hit || wr_first || wr_second || wr_timer;

    // read decode
    wire                   ar_fire     = s_axi_arvalid && s_axi_arready;
    wire [ADDR_W-1:0]      rd_mb_off   = s_axi_araddr - MB_BASE_OFF;
    wire [IDX_W-1:0]       rd_idx      = rd_mb_off[IDX_W+1:2];
    wire                   rd_mb_hit   = (s_axi_araddr >= MB_BASE_OFF)
                                         && (32'(rd_mb_off[ADDR_W-1:2]) < N_MB);
    wire                   rd_first    = s_axi_araddr[ADDR_W-1:2] == FIRST_CTRL_OFF[ADDR_W-1:2];
    wire                   rd_second   = s_axi_araddr[ADDR_W-1:2] == SECOND_CTRL_OFF[ADDR_W-1:2];
    wire                   rd_timer    = s_axi_araddr[ADDR_W-1:2] == TIMER_OFF[ADDR_W-1:2];
    wire                   rd_mapped   = rd_mb_hit || rd_first || rd_second || rd_timer;

    // a lock is released by a timer read or a read of another mailbox
    wire                   unlock      = ar_fire && locked
                                         && (rd_timer || (rd_mb_hit && rd_idx != lock_idx));
    // match enables must see a control write in the same cycle as a code write
    wire                   next_rrs    = (wr_fire && wr_second && wr_strb[0])
                                         ? wr_data[RRS_POS] : remote_request_stored_bit;
    // a fresh frame in the locked mailbox voids the pending read
    wire                   lock_drop   = movein_done && locked && movein_idx == lock_idx;

    wire [DATA_W-1:0]      mb_word [N_MB];
    wire [DATA_W-1:0]      rd_word     = rd_first  ? {31'h0, busy_read_enable_bit} :
                                         rd_second ? {31'h0, remote_request_stored_bit} :
                                         rd_timer  ? {16'h0, timer} :
                                         rd_mb_hit ? mb_word[rd_idx] :
                                                     32'h0;

    assign s_axi_awready = !aw_have && !s_axi_bvalid;
    assign s_axi_wready  = !w_have && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // write address and data are taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            else if (wr_fire)
            begin
                aw_have <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have  <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            else if (wr_fire)
            begin
                w_have  <= 1'b0;
            end
        end
    end

    // write response, unmapped writes answer slverr
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read response, captured at the address handshake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (ar_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // control bits and free-running timer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            busy_read_enable_bit      <= CTRL_BIT_RESET;
            remote_request_stored_bit <= CTRL_BIT_RESET;
            timer                     <= '0;
        end
        else
        begin
            timer <= timer + 1'b1;
            if (wr_fire && wr_first && wr_strb[0])
            begin
                busy_read_enable_bit <= wr_data[BUSY_READ_EN_POS];
            end
            if (wr_fire && wr_second && wr_strb[0])
            begin
                remote_request_stored_bit <= wr_data[RRS_POS];
            end
        end
    end

    // mailbox read lock
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            locked   <= 1'b0;
            lock_idx <= '0;
        end
        else if (ar_fire && rd_mb_hit)
        begin
            locked   <= 1'b1;
            lock_idx <= rd_idx;
        end
        else if (unlock || lock_drop)
        begin
            locked   <= 1'b0;
        end
    end

    // one update path per mailbox
    for (genvar i = 0; i < N_MB; i++)
    begin : g_mb
        wire        cpu_code = wr_fire && wr_mb_hit && wr_idx == IDX_W'(i) && wr_strb[3];
        wire        cpu_rtr  = wr_fire && wr_mb_hit && wr_idx == IDX_W'(i) && wr_strb[2];
        wire        mi_start = movein_start && movein_idx == IDX_W'(i);
        wire        mi_done  = movein_done && movein_idx == IDX_W'(i);
        wire        rr_hit   = remote_req_hit && remote_req_idx == IDX_W'(i);
        wire        tx_hit   = tx_done && tx_idx == IDX_W'(i);
        wire [3:0]  base     = code[i] & BASE_MASK;
        wire        rx_live  = base == RX_EMPTY || base == RX_FULL || base == RX_OVERRUN;
        logic [3:0] next_code;
        logic       next_serviced;
        logic       next_match;
        logic       next_arb;

        assign mb_word[i] = {fdf[i], 3'h0, code[i], 3'h0, rtr[i], 20'h0};

        // engine terms come last so they win over a cpu write
        always_comb
        begin
            next_code = code[i];
            if (cpu_code)
            begin
                next_code = wr_data[CODE_MSB:CODE_LSB];
            end
            if (mi_start && rx_live)
            begin
                next_code = code[i] | BUSY_MASK;
            end
            if (mi_done && rx_live)
            begin
                case (base)
                    RX_EMPTY:   next_code = RX_FULL;
                    RX_FULL:    next_code = serviced[i] ? RX_FULL : RX_OVERRUN;
                    RX_OVERRUN: next_code = serviced[i] ? RX_FULL : RX_OVERRUN;
                    default:    next_code = base;
                endcase
            end
            if (rr_hit && code[i] == RX_ANSWER && !remote_request_stored_bit)
            begin
                next_code = TX_ANSWER;
            end
            if (tx_hit)
            begin
                case (code[i])
                    TX_DATA:   next_code = rtr[i] ? RX_EMPTY : TX_INACTIVE;
                    TX_ANSWER: next_code = RX_ANSWER;
                    default:   next_code = code[i];
                endcase
            end
        end

        // engine clear beats a same-cycle unlock
        assign next_serviced = mi_done ? 1'b0 :
                               cpu_code ? 1'b0 :
                               (unlock && lock_idx == IDX_W'(i)) ? 1'b1 :
                               serviced[i];

        // exact compares keep busy codes out of matching
        assign next_match = next_code == RX_EMPTY || next_code == RX_FULL
                            || next_code == RX_OVERRUN
                            || (next_code == RX_ANSWER && !next_rrs);
        assign next_arb   = next_code == TX_DATA || next_code == TX_ANSWER;

        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                code[i]            <= CODE_RESET;
                rtr[i]             <= 1'b0;
                fdf[i]             <= 1'b0;
                serviced[i]        <= 1'b0;
                rx_match_enable[i] <= 1'b0;
                tx_arb_enable[i]   <= 1'b0;
                tx_remote_frame[i] <= 1'b0;
            end
            else
            begin
                code[i]            <= next_code;
                serviced[i]        <= next_serviced;
                rx_match_enable[i] <= next_match;
                tx_arb_enable[i]   <= next_arb;
                if (cpu_rtr)
                begin
                    rtr[i] <= wr_data[RTR_POS];
                end
                if (cpu_code)
                begin
                    fdf[i] <= wr_data[FDF_POS];
                end
                // reply kind and request sending both follow the rtr bit
                tx_remote_frame[i] <= cpu_rtr ? wr_data[RTR_POS] : rtr[i];
            end
        end
    end

endmodule

`default_nettype wire

/* File: hdl/can_mailbox_pkg.sv */
// constants and codes for the mailbox code state logic
package can_mailbox_pkg;

    localparam int          ADDR_W           = 12;
    localparam int          DATA_W           = 32;
    localparam int          MB_COUNT         = 32;
    localparam int          TIMER_W          = 16;

    localparam logic [11:0] FIRST_CTRL_OFF   = 12'h000;
    localparam logic [11:0] SECOND_CTRL_OFF  = 12'h004;
    localparam logic [11:0] TIMER_OFF        = 12'h008;
    localparam logic [11:0] MB_BASE_OFF      = 12'h080;

    localparam int          CODE_LSB         = 24;
    localparam int          CODE_MSB         = 27;
    localparam int          RTR_POS          = 20;
    localparam int          FDF_POS          = 31;
    localparam int          BUSY_READ_EN_POS = 0;
    localparam int          RRS_POS          = 0;
    localparam int          BUSY_POS         = 0;

    localparam logic [3:0]  BUSY_MASK        = 4'h1;
    localparam logic [3:0]  BASE_MASK        = 4'he;
    localparam logic [3:0]  CODE_RESET       = 4'h0;
    localparam logic        CTRL_BIT_RESET   = 1'b0;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    typedef enum logic [3:0] {
        RX_INACTIVE = 4'b0000,
        RX_EMPTY    = 4'b0100,
        RX_FULL     = 4'b0010,
        RX_OVERRUN  = 4'b0110,
        RX_ANSWER   = 4'b1010,
        TX_INACTIVE = 4'b1000,
        TX_ABORT    = 4'b1001,
        TX_DATA     = 4'b1100,
        TX_ANSWER   = 4'b1110
    } mb_code_t;

endpackage
